// file: logic/seprot_regs.svh
// Constants for the serial EEPROM protect/pause control block
`ifndef SEPROT_REGS_SVH
`define SEPROT_REGS_SVH
`define SEPROT_CMD_LATCH_SET   8'h06
`define SEPROT_CMD_LATCH_CLR   8'h04
`define SEPROT_CMD_STAT_READ   8'h05
`define SEPROT_CMD_STAT_WRITE  8'h01
`define SEPROT_CMD_ARR_READ    8'h03
`define SEPROT_CMD_ARR_WRITE   8'h02
`define SEPROT_CMD_MASK        8'hf7
`define SEPROT_SR_BUSY         0
`define SEPROT_SR_LATCH        1
`define SEPROT_SR_PROT_LO      2
`define SEPROT_SR_PROT_HI      3
`define SEPROT_PROT_QUARTER    7'h60
`define SEPROT_PROT_HALF       7'h40
`define SEPROT_BITS_CMD        6'h08
`define SEPROT_BITS_STAT_WR    6'h10
`define SEPROT_BITS_ADDR       6'h10
`define SEPROT_BITS_BYTE       6'h08
`define SEPROT_WRITE_TIME_NS   5000000
`define SEPROT_CLK_NS          100
`define SEPROT_WRITE_CYCLES    (`SEPROT_WRITE_TIME_NS / `SEPROT_CLK_NS)
`endif

// file: logic/seprot_pkg.sv
// Types for the serial EEPROM protect/pause control block
package seprot_pkg;
  typedef enum logic [2:0] {
    SEPROT_IDLE  = 3'b000, // Standby
    SEPROT_CMD   = 3'b001, // Shifting instruction
    SEPROT_SWR   = 3'b010, // Status write data
    SEPROT_ADDR  = 3'b011, // Array address
    SEPROT_DATA  = 3'b100, // Array write data
    SEPROT_OUT   = 3'b101, // Shifting out
    SEPROT_SKIP  = 3'b110  // Ignore rest of frame
  } seprot_state_t;
  typedef struct packed {
    logic sck;   // Synchronised serial clock
    logic csn;   // Synchronised chip select, low active
    logic sdi;   // Synchronised serial input
    logic wpn;   // Synchronised write protect, low active
    logic holdn; // Synchronised pause, low active
  } seprot_pins_t;
endpackage : seprot_pkg

// file: logic/seprot_sync.sv
// Two-flop synchroniser bank for the serial pins
`timescale 1ns/100ps
`default_nettype none
module seprot_sync
  import seprot_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire seprot_pins_t pinsIn,
  output var  seprot_pins_t pinsOut
);
  seprot_pins_t stage1_r; // First stage, read only by second stage
  seprot_pins_t stage1_nxt;
  seprot_pins_t stage2_nxt;
  // Idle bus levels on reset so no false edge appears
  always_comb begin
    if (!resetn) begin
      stage1_nxt = '{sck: 1'b0, csn: 1'b1, sdi: 1'b0, wpn: 1'b1, holdn: 1'b1};
      stage2_nxt = '{sck: 1'b0, csn: 1'b1, sdi: 1'b0, wpn: 1'b1, holdn: 1'b1};
    end else begin
      stage1_nxt = pinsIn;
      stage2_nxt = stage1_r;
    end
  end
  // Register both stages
  always_ff @(posedge clock) begin
    stage1_r <= stage1_nxt;
    pinsOut  <= stage2_nxt;
  end
endmodule : seprot_sync
`default_nettype wire

// file: logic/seprot_ctrl.sv
// Serial EEPROM slave: status write, block protect, latch, write-protect and pause
//
// Functional notes
// RULE1: Status write changes only block-protect bits
// RULE2: Protect levels: none, 60-7F, 40-7F, all
// RULE3: Status write cycle starts on select rise
// RULE4: Write latch cleared at power-up
// RULE5: Writes refused while write latch clear
// RULE6: Completed writes clear the write latch
// RULE7: Write starts only on exact bit count
// RULE8: Array access ignored during write cycle
// RULE9: Power-up standby, output off, await select fall
// RULE10: Write-protect low blocks array and status writes
// RULE11: Write-protect low holds latch cleared
// RULE12: Running write finishes despite write-protect
// RULE13: Unprotected blocks writable when latch set
// RULE14: Deselect means standby; programming still completes
// RULE15: Standby entered only after programming ends
// RULE16: Output high impedance while deselected
// RULE17: Input sampled on serial clock rise
// RULE18: Output changes after serial clock fall
// RULE19: Pause begins only with serial clock low
// RULE20: Paused: inputs ignored, output tri-stated
// RULE21: Resume only when serial clock low
// RULE22: Host keeps select low during pause
// RULE23: Instruction codes, bit 3 ignored
// RULE24: Status: protect 3:2, latch 1, busy 0
// RULE25: Busy bit high during write cycle
// RULE26: Transfers most significant bit first
// RULE27: Write duration from configurable counter
`timescale 1ns/100ps
`default_nettype none
`include "seprot_regs.svh"
module seprot_ctrl
  import seprot_pkg::*;
#(
  parameter int WRITE_CYCLES = `SEPROT_WRITE_CYCLES
)(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       sckPin,
  input  wire logic       csnPin,
  input  wire logic       sdiPin,
  input  wire logic       wpnPin,
  input  wire logic       holdnPin,
  output logic            sdoOut,
  output logic            sdoOen_n,
  output logic [3:0]      statusOut,
  output logic            writeStart,
  output logic [6:0]      writeAddr,
  output logic            activeOut
);
  seprot_pins_t  pinsSync;       // Synchronised pins
  seprot_pins_t  pinsRaw;        // Raw pins, before the synchroniser
  seprot_state_t state_r, state_nxt;
  logic          sckPrev_r, sckPrev_nxt;   // Last sampled clock level
  logic          paused_r, paused_nxt;     // Pause engaged
  logic [7:0]    shift_r, shift_nxt;       // Input shifter
  logic [7:0]    outSh_r, outSh_nxt;       // Output shifter
  logic [5:0]    bitCnt_r, bitCnt_nxt;     // Bits in current phase
  logic [7:0]    cmd_r, cmd_nxt;           // Masked instruction
  logic          latch_r, latch_nxt;       // Write enable latch
  logic [1:0]    prot_r, prot_nxt;         // Block-protect bits
  logic [1:0]    pendProt_r, pendProt_nxt; // Status data awaiting commit
  logic          armed_r, armed_nxt;       // Frame ended at a byte boundary
  logic [6:0]    addr_r, addr_nxt;         // Array address
  logic [31:0]   busyCnt_r, busyCnt_nxt;   // Write cycle timer
  logic          busy_r, busy_nxt;         // Write in progress
  logic          sdo_r, sdo_nxt;
  logic          oen_r, oen_nxt;
  logic          start_r, start_nxt;
  logic          active_r, active_nxt;
  logic          sckRise, sckFall, csRise;
  logic          csPrev_r, csPrev_nxt;

  // Pins gathered into one word for the synchroniser
  assign pinsRaw = '{sck: sckPin, csn: csnPin, sdi: sdiPin, wpn: wpnPin, holdn: holdnPin};
  seprot_sync u_sync (
    .clock  (clock),
    .resetn (resetn),
    .pinsIn (pinsRaw),
    .pinsOut(pinsSync)
  );

  // Address protected under the current level
  function automatic logic isProtected(input logic [1:0] lvl, input logic [6:0] a);
    isProtected = 1'b0;
    case (lvl)
      2'b01:   isProtected = (a >= `SEPROT_PROT_QUARTER); // RULE2
      2'b10:   isProtected = (a >= `SEPROT_PROT_HALF);    // RULE2
      2'b11:   isProtected = 1'b1;                        // RULE2
      default: isProtected = 1'b0;
    endcase
  endfunction : isProtected

  // Clock edges are ignored while paused
  assign sckRise = pinsSync.sck & ~sckPrev_r & ~paused_r & ~pinsSync.csn;  // RULE17 RULE20
  assign sckFall = ~pinsSync.sck & sckPrev_r & ~paused_r & ~pinsSync.csn;  // RULE18 RULE20
  assign csRise  = pinsSync.csn & ~csPrev_r;

  // Next-state logic for the slave; output enable and activity are set in the next block
  always_comb begin
    state_nxt    = state_r;
    sckPrev_nxt  = pinsSync.sck;
    csPrev_nxt   = pinsSync.csn;
    paused_nxt   = paused_r;
    shift_nxt    = shift_r;
    outSh_nxt    = outSh_r;
    bitCnt_nxt   = bitCnt_r;
    cmd_nxt      = cmd_r;
    latch_nxt    = latch_r;
    prot_nxt     = prot_r;
    pendProt_nxt = pendProt_r;
    armed_nxt    = armed_r;
    addr_nxt     = addr_r;
    busyCnt_nxt  = busyCnt_r;
    busy_nxt     = busy_r;
    sdo_nxt      = sdo_r;
    start_nxt    = 1'b0;
    // Self-timed write; runs regardless of select or protect
    if (busy_r) begin
      if (busyCnt_r == 32'h0000_0001) begin
        busy_nxt = 1'b0;                                 // RULE12 RULE25 RULE27
      end
      busyCnt_nxt = busyCnt_r - 32'h0000_0001;           // RULE27
    end
    // Pause engages only with clock low, releases with clock low or on deselect
    if (pinsSync.holdn == 1'b0 && !pinsSync.sck) begin
      paused_nxt = 1'b1;                                  // RULE19
    end else if (pinsSync.holdn && !pinsSync.sck) begin
      paused_nxt = 1'b0;                                  // RULE21
    end
    if (pinsSync.csn) begin
      paused_nxt = 1'b0;
    end
    // Frame end: commit writes only on exact byte count
    if (csRise) begin
      // Write frames commit here; latch commands act even with the latch already set
      if (state_r == SEPROT_SWR || state_r == SEPROT_DATA) begin    // RULE3
        if (armed_r && latch_r && pinsSync.wpn && !busy_r) begin    // RULE5 RULE7 RULE10
          if (state_r == SEPROT_SWR) begin
            prot_nxt = pendProt_r;                                  // RULE1
          end
          start_nxt   = 1'b1;
          busy_nxt    = 1'b1;
          busyCnt_nxt = 32'(WRITE_CYCLES);                          // RULE27
          latch_nxt   = 1'b0;                                       // RULE6
        end
      end else if (state_r == SEPROT_CMD && armed_r && !busy_r) begin
        if (cmd_r == `SEPROT_CMD_LATCH_SET) begin
          latch_nxt = 1'b1;
        end else if (cmd_r == `SEPROT_CMD_LATCH_CLR) begin
          latch_nxt = 1'b0;
        end
      end
      state_nxt = SEPROT_IDLE;                                      // RULE14
      armed_nxt = 1'b0;
    end else if (!pinsSync.csn && state_r == SEPROT_IDLE && csPrev_r) begin
      // Only a falling select leaves standby
      state_nxt  = SEPROT_CMD;                                      // RULE9
      bitCnt_nxt = 6'h00;
      armed_nxt  = 1'b0;
    end else if (sckRise) begin
      shift_nxt  = {shift_r[6:0], pinsSync.sdi};                    // RULE17 RULE26
      bitCnt_nxt = bitCnt_r + 6'h01;
      armed_nxt  = 1'b0;
      case (state_r)
        SEPROT_CMD: begin
          if (bitCnt_r == `SEPROT_BITS_CMD - 6'h01) begin
            cmd_nxt    = {shift_r[6:0], pinsSync.sdi} & `SEPROT_CMD_MASK; // RULE23
            bitCnt_nxt = 6'h00;
            armed_nxt  = 1'b1;
            if (cmd_nxt == `SEPROT_CMD_STAT_WRITE) begin
              state_nxt = SEPROT_SWR;
              armed_nxt = 1'b0;
            end else if (cmd_nxt == `SEPROT_CMD_STAT_READ) begin
              state_nxt = SEPROT_OUT;
              outSh_nxt = {4'h0, prot_r, latch_r, busy_r};          // RULE24 RULE25
            end else if (cmd_nxt == `SEPROT_CMD_ARR_WRITE || cmd_nxt == `SEPROT_CMD_ARR_READ) begin
              state_nxt = busy_r ? SEPROT_SKIP : SEPROT_ADDR;       // RULE8
              armed_nxt = 1'b0;
            end
          end
        end
        SEPROT_SWR: begin
          if (bitCnt_r == `SEPROT_BITS_BYTE - 6'h01) begin
            pendProt_nxt = {shift_r[`SEPROT_SR_PROT_HI - 1], shift_r[`SEPROT_SR_PROT_LO - 1]}; // RULE1 RULE24
            armed_nxt    = 1'b1;                                    // RULE7
          end else if (bitCnt_r == `SEPROT_BITS_BYTE) begin
            // A ninth status bit spoils the frame for good
            state_nxt    = SEPROT_SKIP;
          end
        end
        SEPROT_ADDR: begin
          if (bitCnt_r == `SEPROT_BITS_BYTE - 6'h01) begin
            addr_nxt   = {shift_r[5:0], pinsSync.sdi};
            bitCnt_nxt = 6'h00;
            if (cmd_r == `SEPROT_CMD_ARR_WRITE) begin
              state_nxt = isProtected(prot_r, addr_nxt) ? SEPROT_SKIP : SEPROT_DATA; // RULE13
            end else begin
              state_nxt = SEPROT_OUT;
              outSh_nxt = 8'h00;
            end
          end
        end
        SEPROT_DATA: begin
          if (bitCnt_r == `SEPROT_BITS_BYTE - 6'h01) begin
            bitCnt_nxt = 6'h00;
            armed_nxt  = 1'b1;                                      // RULE7
          end
        end
        default: begin
          armed_nxt = (state_r == SEPROT_SKIP) ? 1'b0 : armed_r;
        end
      endcase
    end else if (sckFall && state_r == SEPROT_OUT) begin
      sdo_nxt   = outSh_r[7];                                       // RULE18 RULE26
      outSh_nxt = {outSh_r[6:0], outSh_r[7]};
    end
    // Write protect low forces the latch clear
    if (!pinsSync.wpn) begin
      latch_nxt = 1'b0;                                             // RULE11
    end
    if (!resetn) begin
      state_nxt = SEPROT_IDLE;
      latch_nxt = 1'b0;                                             // RULE4
      prot_nxt  = 2'b00;
      busy_nxt  = 1'b0;
      paused_nxt = 1'b0;
      armed_nxt = 1'b0;
      busyCnt_nxt = 32'h0000_0000;
    end
  end

  // Output driver only with select low, not paused, while reading
  always_comb begin
    oen_nxt    = ~(!pinsSync.csn && pinsSync.holdn && !paused_r && state_r == SEPROT_OUT); // RULE16 RULE20
    active_nxt = (state_r != SEPROT_IDLE) || busy_r;                                      // RULE15
    if (!resetn) begin
      oen_nxt    = 1'b1;                                                                   // RULE9
      active_nxt = 1'b0;
    end
  end

  // Register all state
  always_ff @(posedge clock) begin
    state_r    <= state_nxt;
    sckPrev_r  <= sckPrev_nxt;
    csPrev_r   <= resetn ? csPrev_nxt : 1'b1;
    paused_r   <= paused_nxt;
    shift_r    <= shift_nxt;
    outSh_r    <= outSh_nxt;
    bitCnt_r   <= bitCnt_nxt;
    cmd_r      <= cmd_nxt;
    latch_r    <= latch_nxt;
    prot_r     <= prot_nxt;
    pendProt_r <= pendProt_nxt;
    armed_r    <= armed_nxt;
    addr_r     <= addr_nxt;
    busyCnt_r  <= busyCnt_nxt;
    busy_r     <= busy_nxt;
    sdo_r      <= sdo_nxt;
    oen_r      <= oen_nxt;
    start_r    <= resetn ? start_nxt : 1'b0;
    active_r   <= active_nxt;
  end

  // Outputs straight from flops
  always_ff @(posedge clock) begin
    sdoOut     <= resetn ? sdo_nxt : 1'b0;
    sdoOen_n   <= oen_nxt;
    statusOut  <= resetn ? {prot_nxt, latch_nxt, busy_nxt} : 4'h0;
    writeStart <= resetn ? start_nxt : 1'b0;
    writeAddr  <= resetn ? addr_nxt : 7'h00;
    activeOut  <= active_nxt;
  end

  chk_latch_wp_low: assert property (@(posedge clock) disable iff (!resetn)
    !pinsSync.wpn |=> !latch_r) else $error("latch set while protect low"); // RULE11
  chk_busy_start: assert property (@(posedge clock) disable iff (!resetn)
    start_r |-> busy_r && !latch_r) else $error("write start without busy"); // RULE3
  chk_start_needs_latch: assert property (@(posedge clock) disable iff (!resetn)
    start_nxt |-> armed_r && latch_r && pinsSync.wpn && !busy_r) else $error("write without latch"); // RULE5
  chk_oen_deselect: assert property (@(posedge clock) disable iff (!resetn)
    $past(pinsSync.csn) |-> oen_r) else $error("output driven while deselected"); // RULE16
  chk_pause_oen: assert property (@(posedge clock) disable iff (!resetn)
    paused_r |=> oen_r) else $error("output driven while paused"); // RULE20
  chk_busy_holds: assert property (@(posedge clock) disable iff (!resetn)
    $rose(busy_r) |-> busy_r [*8]) else $error("write cycle ended early"); // RULE27
  chk_prot_stable: assert property (@(posedge clock) disable iff (!resetn)
    !start_r |-> $stable(prot_r)) else $error("protect bits changed without write"); // RULE1
  chk_idle_standby: assert property (@(posedge clock) disable iff (!resetn)
    pinsSync.csn && !busy_r && state_r == SEPROT_IDLE |=> !active_r) else $error("not standby"); // RULE15
  // Frame-level guards on refused writes
  chk_wp_no_start: assert property (@(posedge clock) disable iff (!resetn)
    !pinsSync.wpn |-> !start_nxt) else $error("write started under protect pin"); // RULE10
  chk_busy_no_addr: assert property (@(posedge clock) disable iff (!resetn)
    busy_r |-> state_r != SEPROT_ADDR && state_r != SEPROT_DATA) else $error("array access during write"); // RULE8
  chk_protect_refuse: assert property (@(posedge clock) disable iff (!resetn)
    csRise && state_r == SEPROT_DATA |-> !isProtected(prot_r, addr_r)) else $error("protected block written"); // RULE13
  chk_latch_hold_busy: assert property (@(posedge clock) disable iff (!resetn)
    busy_r && !start_r |-> !latch_r) else $error("latch set during write cycle"); // RULE6
endmodule : seprot_ctrl
`default_nettype wire

// file: bench/seprot_host_model.sv
// Host serial master model that drives the pins of the protect/pause block
`timescale 1ns/100ps
`default_nettype none
module seprot_host_model (
  input  wire logic clock,
  input  wire logic sdoOut,
  input  wire logic sdoOen_n,
  output logic      sckPin,
  output logic      csnPin,
  output logic      sdiPin,
  output logic      wpnPin,
  output logic      holdnPin,
  output logic      pauseLeak
);
  logic [31:0] rxBits; // Bits seen on the serial output
  // Idle bus: deselected, clock low, pause unused
  initial begin
    sckPin = 1'b0;
    csnPin = 1'b1;
    sdiPin = 1'b0;
    wpnPin = 1'b1;
    holdnPin = 1'b1;
    pauseLeak = 1'b0;
    rxBits = 32'h0;
  end
  task automatic ticks(input int n);
    repeat (n) @(posedge clock);
  endtask : ticks
  task automatic setWp(input logic v);
    wpnPin <= v;
    ticks(1);
  endtask : setWp
  // Pause with stray edges in between; the clock stays low at both ends
  task automatic pause();
    holdnPin <= 1'b0;
    ticks(6);
    if (sdoOen_n !== 1'b1) pauseLeak = 1'b1;
    sckPin <= 1'b1;
    sdiPin <= ~sdiPin;
    ticks(4);
    sckPin <= 1'b0;
    ticks(4);
    holdnPin <= 1'b1;
    ticks(4);
  endtask : pause
  // One whole frame; the clock only runs while selected
  task automatic frame(input logic [31:0] tx, input int nb, input int pauseAt);
    csnPin <= 1'b0;
    ticks(4);
    for (int i = nb - 1; i >= 0; i--) begin
      if (i == pauseAt) pause();
      sdiPin <= tx[i];
      ticks(4);
      sckPin <= 1'b1;
      ticks(2);
      rxBits = {rxBits[30:0], sdoOut}; // Settled well after the fall
      ticks(2);
      sckPin <= 1'b0;
    end
    ticks(4);
    csnPin <= 1'b1;
    sdiPin <= ~sdiPin; // Released line must not keep a stale value
    ticks(4);
  endtask : frame
endmodule : seprot_host_model
`default_nettype wire

// file: bench/spi_eeprom_protect_hold_ctrl_test.sv
// Self-checking bench for the protect/pause control block
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_protect_hold_ctrl_test
  import seprot_pkg::*;
;
  localparam int WC = 600; // Shortened write time, longer than one frame
  logic       clock, resetn;
  logic       sckPin, csnPin, sdiPin, wpnPin, holdnPin, pauseLeak;
  logic       sdoOut, sdoOen_n, writeStart, activeOut;
  logic [3:0] statusOut;
  logic [6:0] writeAddr;
  int         errors, nTests, starts, busyRun;
  logic [7:0] st;
  seprot_ctrl #(.WRITE_CYCLES(WC)) seprot_ctrl_i (.clock(clock), .resetn(resetn), .sckPin(sckPin),
    .csnPin(csnPin), .sdiPin(sdiPin), .wpnPin(wpnPin), .holdnPin(holdnPin), .sdoOut(sdoOut),
    .sdoOen_n(sdoOen_n), .statusOut(statusOut), .writeStart(writeStart), .writeAddr(writeAddr),
    .activeOut(activeOut));
  seprot_host_model seprot_host_model_i (.clock(clock), .sdoOut(sdoOut), .sdoOen_n(sdoOen_n),
    .sckPin(sckPin), .csnPin(csnPin), .sdiPin(sdiPin), .wpnPin(wpnPin), .holdnPin(holdnPin),
    .pauseLeak(pauseLeak));
  initial clock = 1'b0;
  always #50 clock = ~clock;
  // Start pulses counted, busy length measured from each start
  always @(posedge clock) begin
    if (writeStart === 1'b1) starts <= starts + 1;
    if (writeStart === 1'b1) busyRun <= 0;
    else if (statusOut[0] === 1'b1) busyRun <= busyRun + 1;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // Frame plus room for the start pulse to land
  task automatic xfer(input logic [31:0] tx, input int nb, input int pauseAt);
    seprot_host_model_i.frame(tx, nb, pauseAt);
    seprot_host_model_i.ticks(10);
  endtask : xfer
  task automatic readStatus(input int pauseAt);
    xfer(32'h0500, 16, pauseAt);
    st = seprot_host_model_i.rxBits[7:0];
  endtask : readStatus
  // Bounded wait for the write cycle to end
  task automatic waitBusy();
    for (int k = 0; k < 2 * WC && statusOut[0] !== 1'b0; k++) seprot_host_model_i.ticks(1);
    check("busy cleared", 32'(statusOut[0]), 32'h0);
  endtask : waitBusy
  // Status write with latch set first; expects a start
  task automatic setProt(input logic [1:0] bp, input int pauseAt);
    int s0;
    xfer(32'h06, 8, -1);
    s0 = starts;
    xfer({16'h0, 8'h01, 4'hf, bp, 2'b11}, 16, pauseAt);
    check("status write start", 32'(starts - s0), 32'h1);
    check("status after write", 32'(statusOut), {28'h0, bp, 2'b01});
    waitBusy();
  endtask : setProt
  task automatic t_power();
    check("output enable", 32'(sdoOen_n), 32'h1);
    check("active", 32'(activeOut), 32'h0);
    check("status", 32'(statusOut), 32'h0);
    $display("test power done");
  endtask : t_power
  // Latch codes with the ignored bit both ways, and a bad bit count
  task automatic t_latch();
    logic [7:0] codes [4] = '{8'h06, 8'h04, 8'h0e, 8'h0c};
    for (int i = 0; i < 4; i++) begin
      xfer(32'(codes[i]), 8, -1);
      check("latch", 32'(statusOut[1]), 32'(i % 2 == 0));
    end
    xfer(32'h06, 8, -1);
    xfer(32'h008, 9, -1);
    check("latch odd count", 32'(statusOut[1]), 32'h1);
    $display("test latch done");
  endtask : t_latch
  task automatic t_status();
    for (int bp = 3; bp >= 0; bp--) begin
      setProt(2'(bp), -1);
      check("busy length", 32'(busyRun >= WC - 1 && busyRun <= WC + 1), 32'h1);
      readStatus(-1);
      check("status read", 32'(st[3:0]), {28'h0, 2'(bp), 2'b00});
    end
    $display("test status done");
  endtask : t_status
  task automatic t_refuse();
    int s0;
    s0 = starts;
    xfer(32'h0108, 16, -1);
    check("write without latch", 32'(starts - s0), 32'h0);
    xfer(32'h06, 8, -1);
    xfer(32'h0108 >> 1, 15, -1);
    check("short status write", 32'(starts - s0), 32'h0);
    seprot_host_model_i.setWp(1'b0);
    seprot_host_model_i.ticks(6);
    check("latch under wp", 32'(statusOut[1]), 32'h0);
    xfer(32'h06, 8, -1);
    xfer(32'h0108, 16, -1);
    check("write under wp", 32'(starts - s0), 32'h0);
    readStatus(-1);
    check("read under wp", 32'(st[3:0]), 32'h0);
    seprot_host_model_i.setWp(1'b1);
    $display("test refuse done");
  endtask : t_refuse
  // Block protection table against array writes
  task automatic t_protect();
    logic [9:0] tbl [6] = '{{2'd1, 7'h5f, 1'b1}, {2'd1, 7'h60, 1'b0}, {2'd2, 7'h3f, 1'b1},
                            {2'd2, 7'h40, 1'b0}, {2'd3, 7'h00, 1'b0}, {2'd0, 7'h7f, 1'b1}};
    int s0;
    for (int i = 0; i < 6; i++) begin
      setProt(tbl[i][9:8], -1);
      xfer(32'h06, 8, -1);
      s0 = starts;
      xfer({8'h0, 8'h02, 1'b0, tbl[i][7:1], 8'ha5}, 24, -1);
      check("array write start", 32'(starts - s0), 32'(tbl[i][0]));
      if (tbl[i][0]) check("write address", 32'(writeAddr), 32'(tbl[i][7:1]));
      if (tbl[i][0]) check("latch after write", 32'(statusOut[1]), 32'h0);
      waitBusy();
    end
    $display("test protect done");
  endtask : t_protect
  // Access and write-protect during a running cycle
  task automatic t_busy();
    int s0;
    xfer(32'h06, 8, -1);
    s0 = starts;
    xfer(32'h02105a, 24, -1);
    check("active while writing", 32'(activeOut), 32'h1);
    xfer(32'h06, 8, -1);
    xfer(32'h02115a, 24, -1);
    check("access while busy", 32'(starts - s0), 32'h1);
    check("address kept", 32'(writeAddr), 32'h10);
    seprot_host_model_i.setWp(1'b0);
    seprot_host_model_i.ticks(6);
    check("busy after wp", 32'(statusOut[0]), 32'h1);
    waitBusy();
    check("full length under wp", 32'(busyRun >= WC - 1 && busyRun <= WC + 1), 32'h1);
    seprot_host_model_i.setWp(1'b1);
    $display("test busy done");
  endtask : t_busy
  task automatic t_pause();
    setProt(2'd2, 5);
    readStatus(3);
    check("read across pause", 32'(st[3:0]), 32'h8);
    check("output off in pause", 32'(pauseLeak), 32'h0);
    $display("test pause done");
  endtask : t_pause
  // Hang guard: about four times the expected run length
  initial begin
    #(60000 * 100);
    errors++;
    final_report();
  end
  initial begin
    resetn = 1'b0;
    errors = 0;
    nTests = 0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    t_power();
    t_latch();
    t_status();
    t_refuse();
    t_protect();
    t_busy();
    t_pause();
    final_report();
  end
endmodule : spi_eeprom_protect_hold_ctrl_test
`default_nettype wire
